// File: design/twm_pkg.sv
package twm_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_CMP_A = 8'h14;
  localparam logic [7:0] OFS_CMP_B = 8'h18;
  localparam logic [7:0] OFS_CMP_C = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // Bit 13 is unused in both layouts of the mode register and reads as zero.
  localparam logic [31:0] MODE_WMASK = 32'hFFFF_DFFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Command bits of the write-only control register.
  localparam int CTL_CLK_EN = 0;
  localparam int CTL_CLK_DIS = 1;
  localparam int CTL_SOFT_TRIG = 2;

  // Mode register fields, common part.
  localparam int F_CLK_SRC = 0;
  localparam int F_CLK_INV = 3;
  localparam int F_GATE = 4;
  localparam int F_STOP_C = 6;
  localparam int F_DIS_C = 7;
  localparam int F_EV_EDGE = 8;
  localparam int F_EV_SRC = 10;
  localparam int F_EV_RESTART = 12;
  localparam int F_C_RESTART = 14;
  localparam int F_WAVE = 15;
  // Capture layout.
  localparam int F_CAP_A = 16;
  localparam int F_CAP_B = 18;
  // Waveform layout.
  localparam int F_A_ON_A = 16;
  localparam int F_A_ON_C = 18;
  localparam int F_A_ON_EV = 20;
  localparam int F_A_ON_SW = 22;
  localparam int F_B_ON_B = 24;
  localparam int F_B_ON_C = 26;
  localparam int F_B_ON_EV = 28;
  localparam int F_B_ON_SW = 30;

  // Status register bits.
  localparam int ST_CLK_ON = 16;
  localparam int ST_PIN_A = 17;
  localparam int ST_PIN_B = 18;

  // Prescaler taps: bit k of a free-running counter is master clock / 2^(k+1).
  localparam int PRESC_W = 10;
  localparam int DIV2_BIT = 0;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  localparam int DIV128_BIT = 6;
  localparam int DIV1024_BIT = 9;

  // Synchronised inputs.
  localparam int IN_EXT0 = 0;
  localparam int IN_PIN_A = 3;
  localparam int IN_PIN_B = 4;
  localparam int N_IN = 5;

  typedef enum logic [2:0] {
    CLK_DIV2 = 3'b000,
    CLK_DIV8 = 3'b001,
    CLK_DIV32 = 3'b010,
    CLK_DIV128 = 3'b011,
    CLK_DIV1024 = 3'b100,
    CLK_EXT0 = 3'b101,
    CLK_EXT1 = 3'b110,
    CLK_EXT2 = 3'b111
  } twm_clk_src_t;

  typedef enum logic [1:0] {
    PIN_KEEP = 2'b00,
    PIN_SET = 2'b01,
    PIN_CLEAR = 2'b10,
    PIN_TOGGLE = 2'b11
  } twm_pin_act_t;

  // Edge codes: bit 0 selects rising, bit 1 falling, both means each edge.
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic pin_next(input logic cur, input twm_pin_act_t act);
    logic r;
    r = cur;
    unique case (act)
      PIN_KEEP: r = cur;
      PIN_SET: r = 1'b1;
      PIN_CLEAR: r = 1'b0;
      PIN_TOGGLE: r = ~cur;
    endcase
    return r;
  endfunction

endpackage

// File: design/twm_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface twm_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// File: design/twm_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module twm_sync_edge (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and its synchronised view.
  input wire logic din,
  twm_edge_if.src eo
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only the second stage feeds the edge logic; the first settles metastability.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign eo.level = sync_q;
  assign eo.rise = sync_q & ~prev_q;
  assign eo.fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// File: design/twm_timer_channel.sv
// Notes on behaviour
// - With restart-on-C set, a C match zeroes the counter and starts its clock.
// - Waveform bit chooses capture (0) or waveform generation (1).
// - Capture mode loads register A on none, rising, falling or each pin A edge.
// - Capture mode loads register B on none, rising, falling or each pin A edge.
// - Clock source picks master clock /2,/8,/32,/128,/1024 or external lines 0-2.
// - Clock invert counts on the rising edge when 0, falling edge when 1.
// - Gate field leaves the clock ungated or ANDs it with external line 0-2.
// - In waveform mode stop-on-C stops the counter clock at a C match.
// - In waveform mode disable-on-C disables the counter clock at a C match.
// - Event edge field detects none, rising, falling or both edges.
// - Event source is pin B (then an input) or external line 0-2.
// - With event restart set, an event zeroes the counter and starts its clock.
// - A match sets, clears, toggles or keeps pin A per its field.
// - C match sets, clears, toggles or keeps pin A per its field.
// - External event sets, clears, toggles or keeps pin A per its field.
// - Software trigger sets, clears, toggles or keeps pin A per its field.
// - B match sets, clears, toggles or keeps pin B per its field.
// - C match sets, clears, toggles or keeps pin B per its field.
// - External event sets, clears, toggles or keeps pin B per its field.
// - Software trigger sets, clears, toggles or keeps pin B per its field.
// - Counter value register is read-only, resets to zero, count in bits 15:0.
// - Software trigger zeroes the counter and starts its clock.
// - Clock enable acts only without a simultaneous disable; disable wins.
`timescale 1ns/1ps
`default_nettype none
module twm_timer_channel
  import twm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External clock lines.
  input wire logic [2:0] EXT_CLOCK_LINE,
  // Waveform pin A.
  input wire logic WAVE_PIN_A_I,
  output logic WAVE_PIN_A_O,
  output logic WAVE_PIN_A_OE,
  // Waveform pin B.
  input wire logic WAVE_PIN_B_I,
  output logic WAVE_PIN_B_O,
  output logic WAVE_PIN_B_OE
);

  generate
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie between 1 and 32");
    end
  endgenerate

  // Synchronised inputs: external lines 0..2, then pin A, then pin B.
  logic [N_IN-1:0] in_raw;
  logic [N_IN-1:0] in_lvl;
  logic [N_IN-1:0] in_rise;
  logic [N_IN-1:0] in_fall;

  assign in_raw = {WAVE_PIN_B_I, WAVE_PIN_A_I, EXT_CLOCK_LINE};

  twm_edge_if eif [N_IN] ();

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      twm_sync_edge u_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .din(in_raw[gi]),
        .eo(eif[gi])
      );
      assign in_lvl[gi] = eif[gi].level;
      assign in_rise[gi] = eif[gi].rise;
      assign in_fall[gi] = eif[gi].fall;
    end
  endgenerate

  logic [2:0] ext_lvl;
  logic [2:0] ext_rise;
  logic [2:0] ext_fall;
  assign ext_lvl = in_lvl[IN_EXT0 +: 3];
  assign ext_rise = in_rise[IN_EXT0 +: 3];
  assign ext_fall = in_fall[IN_EXT0 +: 3];

  // State.
  logic [31:0] mode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_b_q;
  logic [CNT_W-1:0] cmp_c_q;
  logic cnt_new_q;
  logic clk_on_q;
  logic stopped_q;
  logic [PRESC_W-1:0] presc_q;
  logic gclk_prev_q;
  logic pin_a_q;
  logic pin_b_q;
  logic pin_a_oe_q;
  logic pin_b_oe_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Mode fields.
  logic wave;
  twm_clk_src_t clk_src;
  logic clk_inv;
  logic [1:0] gate_sel;
  logic stop_on_c_match;
  logic disable_on_c_match;
  logic [1:0] event_edge_sel;
  logic [1:0] event_source_sel;
  logic event_restart_en;
  logic c_compare_restart_en;
  logic [1:0] capture_a_load_edge;
  logic [1:0] capture_b_load_edge;

  assign wave = mode_q[F_WAVE];
  assign clk_src = twm_clk_src_t'(mode_q[F_CLK_SRC +: 3]);
  assign clk_inv = mode_q[F_CLK_INV];
  assign gate_sel = mode_q[F_GATE +: 2];
  assign stop_on_c_match = mode_q[F_STOP_C];
  assign disable_on_c_match = mode_q[F_DIS_C];
  assign event_edge_sel = mode_q[F_EV_EDGE +: 2];
  assign event_source_sel = mode_q[F_EV_SRC +: 2];
  assign event_restart_en = mode_q[F_EV_RESTART];
  assign c_compare_restart_en = mode_q[F_C_RESTART];
  assign capture_a_load_edge = mode_q[F_CAP_A +: 2];
  assign capture_b_load_edge = mode_q[F_CAP_B +: 2];

  // APB decode. A transfer completes at the edge where PREADY is seen high.
  logic acc;
  logic done;
  logic wr_go;
  logic hit_ctrl;
  logic hit_mode;
  logic hit_count;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_status;
  logic mapped;

  assign acc = PSEL & PENABLE;
  assign done = acc & pready_q;
  assign wr_go = done & PWRITE;
  assign hit_ctrl = (PADDR == OFS_CTRL);
  assign hit_mode = (PADDR == OFS_MODE);
  assign hit_count = (PADDR == OFS_COUNT);
  assign hit_a = (PADDR == OFS_CMP_A);
  assign hit_b = (PADDR == OFS_CMP_B);
  assign hit_c = (PADDR == OFS_CMP_C);
  assign hit_status = (PADDR == OFS_STATUS);
  assign mapped = hit_ctrl | hit_mode | hit_count | hit_a | hit_b | hit_c | hit_status;

  // Channel commands, each a one-cycle pulse on the completing write.
  logic cmd_en;
  logic cmd_dis;
  logic cmd_sw;
  assign cmd_en = wr_go & hit_ctrl & PWDATA[CTL_CLK_EN];
  assign cmd_dis = wr_go & hit_ctrl & PWDATA[CTL_CLK_DIS];
  assign cmd_sw = wr_go & hit_ctrl & PWDATA[CTL_SOFT_TRIG];

  // Counter clock: divider taps or external lines, gated, then edge-picked.
  logic [4:0] div_lvl;
  logic sel_lvl;
  logic gate_lvl;
  logic gclk_lvl;
  logic gclk_rise;
  logic gclk_fall;
  logic run;
  logic tick;

  assign div_lvl = {presc_q[DIV1024_BIT], presc_q[DIV128_BIT], presc_q[DIV32_BIT],
                    presc_q[DIV8_BIT], presc_q[DIV2_BIT]};
  assign sel_lvl = (clk_src == CLK_DIV2) ? div_lvl[0] :
                   (clk_src == CLK_DIV8) ? div_lvl[1] :
                   (clk_src == CLK_DIV32) ? div_lvl[2] :
                   (clk_src == CLK_DIV128) ? div_lvl[3] :
                   (clk_src == CLK_DIV1024) ? div_lvl[4] :
                   (clk_src == CLK_EXT0) ? ext_lvl[0] :
                   (clk_src == CLK_EXT1) ? ext_lvl[1] : ext_lvl[2];
  assign gate_lvl = (gate_sel == 2'h0) ? 1'b1 :
                    (gate_sel == 2'h1) ? ext_lvl[0] :
                    (gate_sel == 2'h2) ? ext_lvl[1] : ext_lvl[2];
  assign gclk_lvl = sel_lvl & gate_lvl;
  assign gclk_rise = gclk_lvl & ~gclk_prev_q;
  assign gclk_fall = ~gclk_lvl & gclk_prev_q;
  assign run = clk_on_q & ~stopped_q;
  assign tick = run & (clk_inv ? gclk_fall : gclk_rise);

  // Compare matches fire once, in the cycle after the count steps onto the value.
  logic a_match;
  logic b_match;
  logic c_match;
  assign a_match = wave & cnt_new_q & (cnt_q == cmp_a_q);
  assign b_match = wave & cnt_new_q & (cnt_q == cmp_b_q);
  assign c_match = cnt_new_q & (cnt_q == cmp_c_q);

  // External event.
  logic ev_rise;
  logic ev_fall;
  logic ev_hit;
  assign ev_rise = (event_source_sel == 2'h0) ? in_rise[IN_PIN_B] :
                   ext_rise[event_source_sel - 2'h1];
  assign ev_fall = (event_source_sel == 2'h0) ? in_fall[IN_PIN_B] :
                   ext_fall[event_source_sel - 2'h1];
  assign ev_hit = wave & edge_hit(event_edge_sel, ev_rise, ev_fall);

  // Restart sources and clock control.
  logic trig;
  logic stop_hit;
  logic dis_hit;
  assign trig = cmd_sw
              | (c_match & c_compare_restart_en)
              | (ev_hit & event_restart_en);
  assign stop_hit = wave & stop_on_c_match & c_match;
  assign dis_hit = wave & disable_on_c_match & c_match;

  logic clk_on_d;
  logic stopped_d;
  logic [CNT_W-1:0] cnt_d;
  // A disable, by command or by C match, outranks any enable or restart.
  assign clk_on_d = (cmd_dis | dis_hit) ? 1'b0 :
                    (cmd_en | trig) ? 1'b1 : clk_on_q;
  assign stopped_d = (trig | cmd_en) ? 1'b0 : stop_hit ? 1'b1 : stopped_q;
  assign cnt_d = trig ? '0 : tick ? cnt_q + 1'b1 : cnt_q;

  // Capture loads from pin A, only in capture mode.
  logic cap_a_hit;
  logic cap_b_hit;
  assign cap_a_hit = ~wave & edge_hit(capture_a_load_edge, in_rise[IN_PIN_A],
                                      in_fall[IN_PIN_A]);
  assign cap_b_hit = ~wave & edge_hit(capture_b_load_edge, in_rise[IN_PIN_A],
                                      in_fall[IN_PIN_A]);

  // Pin actions. When several events coincide, the highest one decides alone:
  // software trigger, then external event, then C match, then A or B match.
  twm_pin_act_t act_a;
  twm_pin_act_t act_b;
  assign act_a = cmd_sw ? twm_pin_act_t'(mode_q[F_A_ON_SW +: 2]) :
                 ev_hit ? twm_pin_act_t'(mode_q[F_A_ON_EV +: 2]) :
                 c_match ? twm_pin_act_t'(mode_q[F_A_ON_C +: 2]) :
                 a_match ? twm_pin_act_t'(mode_q[F_A_ON_A +: 2]) : PIN_KEEP;
  assign act_b = cmd_sw ? twm_pin_act_t'(mode_q[F_B_ON_SW +: 2]) :
                 ev_hit ? twm_pin_act_t'(mode_q[F_B_ON_EV +: 2]) :
                 c_match ? twm_pin_act_t'(mode_q[F_B_ON_C +: 2]) :
                 b_match ? twm_pin_act_t'(mode_q[F_B_ON_B +: 2]) : PIN_KEEP;

  logic pin_a_d;
  logic pin_b_d;
  logic pin_b_drive;
  assign pin_a_d = wave ? pin_next(pin_a_q, act_a) : pin_a_q;
  assign pin_b_d = wave ? pin_next(pin_b_q, act_b) : pin_b_q;
  // Pin B turns into the event input when it is chosen as the event source.
  assign pin_b_drive = wave & (event_source_sel != 2'h0);

  // Read data. Each status mirror shows the driven level while its pin's output
  // enable is set and the pin level otherwise.
  logic mirror_a;
  logic mirror_b;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  assign mirror_a = pin_a_oe_q ? pin_a_q : in_lvl[IN_PIN_A];
  assign mirror_b = pin_b_oe_q ? pin_b_q : in_lvl[IN_PIN_B];
  assign status_word = (32'(clk_on_q) << ST_CLK_ON) | (32'(mirror_a) << ST_PIN_A)
                     | (32'(mirror_b) << ST_PIN_B);
  assign rd_mux = hit_mode ? mode_q :
                  hit_count ? 32'(cnt_q) :
                  hit_a ? 32'(cmp_a_q) :
                  hit_b ? 32'(cmp_b_q) :
                  hit_c ? 32'(cmp_c_q) :
                  hit_status ? status_word : WORD_ZERO;

  // Bus answer: one wait state, data and error registered with PREADY.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WORD_ZERO;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      if (acc & ~pready_q) begin
        prdata_q <= PWRITE ? WORD_ZERO : rd_mux;
      end
    end
  end

  // Configuration and compare registers. A and B are writable only in
  // waveform mode; in capture mode the pin edges own them.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mode_q <= MODE_RESET;
      cmp_a_q <= '0;
      cmp_b_q <= '0;
      cmp_c_q <= '0;
    end else begin
      if (wr_go & hit_mode) begin
        mode_q <= PWDATA & MODE_WMASK;
      end
      if (cap_a_hit) begin
        cmp_a_q <= cnt_q;
      end else if (wr_go & hit_a & wave) begin
        cmp_a_q <= PWDATA[CNT_W-1:0];
      end
      if (cap_b_hit) begin
        cmp_b_q <= cnt_q;
      end else if (wr_go & hit_b & wave) begin
        cmp_b_q <= PWDATA[CNT_W-1:0];
      end
      if (wr_go & hit_c) begin
        cmp_c_q <= PWDATA[CNT_W-1:0];
      end
    end
  end

  // Counter and its clock. A bus write reaches cnt_q only as a software trigger, which zeroes it.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      presc_q <= '0;
      gclk_prev_q <= 1'b0;
      cnt_q <= '0;
      cnt_new_q <= 1'b0;
      clk_on_q <= 1'b0;
      stopped_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 1'b1;
      gclk_prev_q <= gclk_lvl;
      cnt_q <= cnt_d;
      cnt_new_q <= tick & ~trig;
      clk_on_q <= clk_on_d;
      stopped_q <= stopped_d;
    end
  end

  // Waveform pins. Both float in capture mode.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
    end else begin
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      pin_a_oe_q <= wave;
      pin_b_oe_q <= pin_b_drive;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign WAVE_PIN_A_O = pin_a_q;
  assign WAVE_PIN_A_OE = pin_a_oe_q;
  assign WAVE_PIN_B_O = pin_b_q;
  assign WAVE_PIN_B_OE = pin_b_oe_q;

endmodule
`default_nettype wire

// File: tb/twm_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module twm_pin_partner (
  // Channel pin drivers.
  input wire logic oe_a,
  input wire logic o_a,
  input wire logic oe_b,
  input wire logic o_b,
  // Levels the outside world puts on a pin the channel leaves alone.
  input wire logic lvl_a,
  input wire logic lvl_b,
  // Resolved wire levels.
  output logic pin_a,
  output logic pin_b
);
  // A pin is an input to the channel whenever its enable is low.
  assign pin_a = oe_a ? o_a : lvl_a;
  assign pin_b = oe_b ? o_b : lvl_b;
endmodule
`default_nettype wire

// File: tb/twm_timer_channel_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module twm_timer_channel_monitor
  import twm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // External lines and pins.
  input wire logic [2:0] EXT_CLOCK_LINE,
  input wire logic WAVE_PIN_A_I,
  input wire logic WAVE_PIN_A_O,
  input wire logic WAVE_PIN_A_OE,
  input wire logic WAVE_PIN_B_I,
  input wire logic WAVE_PIN_B_O,
  input wire logic WAVE_PIN_B_OE
);
  logic [31:0] mode_q;
  logic wr_done;
  logic rd_done;
  logic wr_mode;
  logic trig_wr;
  logic mapped;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
  assign wr_mode = wr_done && PADDR == OFS_MODE;
  assign trig_wr = wr_done && PADDR == OFS_CTRL && PWDATA[CTL_SOFT_TRIG] && !PWDATA[CTL_CLK_DIS];
  assign mapped = PADDR inside {OFS_CTRL, OFS_MODE, OFS_COUNT, OFS_CMP_A, OFS_CMP_B,
                                OFS_CMP_C, OFS_STATUS};

  // A shadow of the mode word lets the pin enables be judged from bus traffic alone.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= PWDATA & MODE_WMASK;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_wait_state;
    !PREADY ##1 PREADY ##1 !PREADY;
  endsequence
  property p_one_wait;
    PSEL && $rose(PENABLE) |-> s_wait_state;
  endproperty
  property p_err_map;
    PREADY |-> PSLVERR == !mapped;
  endproperty
  property p_oe_a;
    !wr_mode [*3] |-> WAVE_PIN_A_OE == mode_q[F_WAVE];
  endproperty
  property p_oe_b;
    !wr_mode [*3] |-> WAVE_PIN_B_OE == (mode_q[F_WAVE] && mode_q[F_EV_SRC +: 2] != 2'b00);
  endproperty
  property p_mode_read;
    rd_done && PADDR == OFS_MODE |-> PRDATA == mode_q;
  endproperty
  property p_count_hi;
    rd_done && PADDR == OFS_COUNT |-> (PRDATA >> CNT_W) == 32'h0000_0000;
  endproperty
  property p_trig_a;
    trig_wr && mode_q[F_WAVE] && mode_q[F_A_ON_SW +: 2] == PIN_SET |-> ##[1:3] WAVE_PIN_A_O;
  endproperty
  property p_trig_b;
    trig_wr && mode_q[F_WAVE] && mode_q[F_EV_SRC +: 2] != 2'b00
      && mode_q[F_B_ON_SW +: 2] == PIN_CLEAR |-> ##[1:3] !WAVE_PIN_B_O;
  endproperty

  a_one_wait: assert property (p_one_wait) else $error("ready timing wrong");
  a_err_map: assert property (p_err_map) else $error("slave error wrong");
  a_oe_a: assert property (p_oe_a) else $error("pin A enable wrong");
  a_oe_b: assert property (p_oe_b) else $error("pin B enable wrong");
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
  a_count_hi: assert property (p_count_hi) else $error("count upper bits set");
  a_trig_a: assert property (p_trig_a) else $error("pin A not set");
  a_trig_b: assert property (p_trig_b) else $error("pin B not cleared");

  c_wave: cover property (wr_mode && PWDATA[F_WAVE]);
  c_trig: cover property (trig_wr && mode_q[F_WAVE]);
  c_err: cover property (PREADY && PSLVERR);
endmodule

bind twm_timer_channel twm_timer_channel_monitor #(.CNT_W(CNT_W)) i_twm_timer_channel_monitor (
  .CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .PSLVERR, .EXT_CLOCK_LINE, .WAVE_PIN_A_I, .WAVE_PIN_A_O, .WAVE_PIN_A_OE,
  .WAVE_PIN_B_I, .WAVE_PIN_B_O, .WAVE_PIN_B_OE
);
`default_nettype wire

// File: tb/twm_timer_channel_test.sv
`timescale 1ns/1ps
`default_nettype none
module twm_timer_channel_test
  import twm_pkg::*;
;
  logic CORE_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [2:0] EXT_CLOCK_LINE;
  logic WAVE_PIN_A_I, WAVE_PIN_A_O, WAVE_PIN_A_OE, WAVE_PIN_B_I, WAVE_PIN_B_O, WAVE_PIN_B_OE;
  logic lvl_a, lvl_b, er;
  int n_mismatch = 0;
  int samples_checked = 0;

  twm_timer_channel #(.CNT_W(16)) i_twm_timer_channel (
    .CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .EXT_CLOCK_LINE, .WAVE_PIN_A_I, .WAVE_PIN_A_O, .WAVE_PIN_A_OE,
    .WAVE_PIN_B_I, .WAVE_PIN_B_O, .WAVE_PIN_B_OE
  );
  twm_pin_partner i_twm_pin_partner (
    .oe_a(WAVE_PIN_A_OE), .o_a(WAVE_PIN_A_O), .oe_b(WAVE_PIN_B_OE), .o_b(WAVE_PIN_B_O),
    .lvl_a(lvl_a), .lvl_b(lvl_b), .pin_a(WAVE_PIN_A_I), .pin_b(WAVE_PIN_B_I)
  );

  function automatic logic eff(input logic cur, input logic [1:0] c);
    return c == 2'b00 ? cur : c == 2'b01 ? 1'b1 : c == 2'b10 ? 1'b0 : !cur;
  endfunction

  task automatic conclude();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  // Each transfer starts one edge later, so a release is never overwritten in its time step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n == 50)
      n_mismatch++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic trig();
    apb(1'b1, OFS_CTRL, 32'h0000_0004);
  endtask

  task automatic t_regs();
    rdchk(OFS_MODE, MODE_RESET);
    rdchk(OFS_COUNT, 32'h0000_0000);
    apb(1'b1, OFS_COUNT, 32'hFFFF_FFFF);
    rdchk(OFS_COUNT, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    rdchk(OFS_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    rdchk(OFS_STATUS, 32'h0001_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    rdchk(OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b1, OFS_MODE, 32'hFFFF_FFFF);
    rdchk(OFS_MODE, MODE_WMASK);
    chk({WAVE_PIN_A_OE, WAVE_PIN_B_OE}, 2'b11);
  endtask

  // The prescaler runs free, so the first tick lands anywhere within one period.
  task automatic t_clk_div();
    int ex;
    for (int k = 0; k < 5; k++) begin
      ex = (k == 4) ? 2 : 1024 >> (2 * k);
      apb(1'b1, OFS_MODE, 32'(k));
      trig();
      cyc(2048);
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      chk(rd >= ex - 1 && rd <= ex + 3, 1'b1);
    end
  endtask

  task automatic t_clk_ext();
    for (int k = 0; k < 3; k++) begin
      for (int inv = 0; inv < 2; inv++) begin
        apb(1'b1, OFS_MODE, 32'(5 + k + 8 * inv));
        trig();
        EXT_CLOCK_LINE[k] <= 1'b1;
        cyc(8);
        rdchk(OFS_COUNT, 32'(1 - inv));
        EXT_CLOCK_LINE[k] <= 1'b0;
        cyc(8);
        rdchk(OFS_COUNT, 32'h0000_0001);
      end
    end
  endtask

  task automatic t_gate();
    for (int g = 1; g < 4; g++) begin
      apb(1'b1, OFS_MODE, 32'(g << 4));
      trig();
      cyc(20);
      rdchk(OFS_COUNT, 32'h0000_0000);
      EXT_CLOCK_LINE[g - 1] <= 1'b1;
      cyc(20);
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      chk(rd > 5, 1'b1);
      EXT_CLOCK_LINE[g - 1] <= 1'b0;
    end
  endtask

  task automatic t_compare();
    apb(1'b1, OFS_MODE, 32'h4E8D_8440);
    apb(1'b1, OFS_CMP_A, 32'h0000_0002);
    apb(1'b1, OFS_CMP_B, 32'h0000_0003);
    apb(1'b1, OFS_CMP_C, 32'h0000_0006);
    trig();
    cyc(40);
    rdchk(OFS_COUNT, 32'h0000_0006);
    chk({WAVE_PIN_A_O, WAVE_PIN_B_O}, 2'b01);
    apb(1'b1, OFS_MODE, 32'h4E8D_8480);
    trig();
    cyc(40);
    rdchk(OFS_COUNT, 32'h0000_0006);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd[ST_CLK_ON], 1'b0);
    apb(1'b1, OFS_MODE, 32'h4E8D_C400);
    trig();
    cyc(41);
    apb(1'b0, OFS_COUNT, 32'h0000_0000);
    chk(rd < 7, 1'b1);
  endtask

  task automatic t_event();
    logic a0, b0;
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, OFS_MODE, 32'h3030_9800 | 32'(e << 8));
      trig();
      cyc(40);
      a0 = WAVE_PIN_A_O;
      b0 = WAVE_PIN_B_O;
      EXT_CLOCK_LINE[1] <= 1'b1;
      cyc(6);
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      chk(rd < 8, 32'(e & 1));
      chk({WAVE_PIN_A_O, WAVE_PIN_B_O}, {a0, b0} ^ {2{e[0]}});
      EXT_CLOCK_LINE[1] <= 1'b0;
      cyc(8);
      chk({WAVE_PIN_A_O, WAVE_PIN_B_O}, {a0, b0} ^ {2{e[0] ^ e[1]}});
    end
    // Pin B as the event source turns into an input, and its rising edge toggles pin A.
    apb(1'b1, OFS_MODE, 32'h0030_8100);
    cyc(4);
    a0 = WAVE_PIN_A_O;
    lvl_b <= 1'b1;
    cyc(8);
    chk({WAVE_PIN_A_O, WAVE_PIN_B_OE}, {!a0, 1'b0});
    lvl_b <= 1'b0;
  endtask

  task automatic t_soft();
    logic [1:0] seq [5] = '{2'b01, 2'b11, 2'b10, 2'b11, 2'b00};
    logic a, b;
    a = WAVE_PIN_A_O;
    b = WAVE_PIN_B_O;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_MODE, {~seq[i], 6'h00, seq[i], 22'h00_8405});
      trig();
      cyc(3);
      a = eff(a, seq[i]);
      b = eff(b, ~seq[i]);
      chk({WAVE_PIN_A_O, WAVE_PIN_B_O}, {a, b});
      rdchk(OFS_COUNT, 32'h0000_0000);
    end
  endtask

  task automatic t_capture();
    // Park with no loads first, since pin A losing its driver can look like an edge.
    apb(1'b1, OFS_MODE, 32'h0000_0000);
    cyc(4);
    apb(1'b1, OFS_MODE, 32'h0009_0000);
    trig();
    cyc(40);
    lvl_a <= 1'b1;
    cyc(8);
    apb(1'b0, OFS_CMP_A, 32'h0000_0000);
    chk(rd > 10, 1'b1);
    rdchk(OFS_CMP_B, 32'h0000_0003);
    lvl_a <= 1'b0;
    cyc(8);
    apb(1'b0, OFS_CMP_B, 32'h0000_0000);
    chk(rd > 10, 1'b1);
  endtask

  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    EXT_CLOCK_LINE = 3'h0;
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    repeat (20) @(posedge CORE_CLK);
    RESET <= 1'b0;
    t_regs();
    t_clk_div();
    t_clk_ext();
    t_gate();
    t_compare();
    t_event();
    t_soft();
    t_capture();
    conclude();
  end

  initial begin
    repeat (30000) @(posedge CORE_CLK);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
